// File: apst_core.sv
// autonomous power state transition core: config bit, transition table, idle timer
// assumes command, activity and power state inputs come from logic on mclk
// Contract
// - transitions only while enable bit is one
// - enable bit resets to zero
// - get returns enable and full table
// - 32 entries of 64 bits, state order
// - unsupported state entries read all zero
// - bits 31:08 give idle time in ms
// - zero idle time blocks transitions from state
// - idle exceeding time moves to bits 07:03
`timescale 1ns/1ps
module apst_core
	import apst_pkg::*;
#(
	parameter int unsigned NUM_PS     = NUM_ENTRIES,
	parameter int unsigned TICK_CYCLES = MS_CYCLES
) (
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 srst,
	// set features: config dword
	input  wire logic                 cfg_wr,
	input  wire logic [31:0]          cfg_wr_data,
	// set features: table entry write
	input  wire logic                 tbl_wr,
	input  wire logic [IDX_W-1:0]     tbl_wr_idx,
	input  wire logic [ENTRY_W-1:0]   tbl_wr_data,
	// get features
	input  wire logic                 tbl_rd,
	input  wire logic [IDX_W-1:0]     tbl_rd_idx,
	output logic      [ENTRY_W-1:0]   tbl_rd_data,
	output logic                      tbl_rd_valid,
	output logic      [31:0]          cfg_rd_data,
	// activity and power state
	input  wire logic                 busy,
	input  wire logic                 ps_set,
	input  wire logic [IDLE_TARGET_POWER_STATE_W-1:0]    ps_set_value,
	output logic      [IDLE_TARGET_POWER_STATE_W-1:0]    cur_ps,
	output logic                      auto_trans
);
	// elaboration-time refusal of parameters the logic cannot serve
	if (NUM_PS < 1 || NUM_PS > NUM_ENTRIES || TICK_CYCLES < 1) begin : g_bad_param
		$error("apst_core: bad parameter");
	end

	// ========================================
	// configuration and table storage
	logic                     auto_power_transition_enable_q;
	logic [IDLE_TIME_BEFORE_TRANSITION_W-1:0]        idle_time_before_transition_q [NUM_ENTRIES];
	logic [IDLE_TARGET_POWER_STATE_W-1:0]        idle_target_power_state_q     [NUM_ENTRIES];

	always_ff @(posedge mclk) begin
		if (srst)
			auto_power_transition_enable_q <= CFG_EN_RESET;
		else if (cfg_wr)
			auto_power_transition_enable_q <= cfg_wr_data[CFG_EN_BIT];
	end

	genvar g;
	generate
		for (g = 0; g < NUM_ENTRIES; g++) begin : g_entry
			wire wr_hit = tbl_wr && (tbl_wr_idx == IDX_W'(g));
			always_ff @(posedge mclk) begin
				if (srst || g >= NUM_PS) begin
					idle_time_before_transition_q[g] <= '0;
					idle_target_power_state_q[g]     <= '0;
				end else if (wr_hit) begin
					idle_time_before_transition_q[g] <= tbl_wr_data[IDLE_TIME_BEFORE_TRANSITION_LSB +: IDLE_TIME_BEFORE_TRANSITION_W];
					idle_target_power_state_q[g]     <= tbl_wr_data[IDLE_TARGET_POWER_STATE_LSB +: IDLE_TARGET_POWER_STATE_W];
				end
			end
		end
	endgenerate

	// ========================================
	// get features read path
	function automatic logic [ENTRY_W-1:0] pack_entry(input logic [IDLE_TIME_BEFORE_TRANSITION_W-1:0] t, input logic [IDLE_TARGET_POWER_STATE_W-1:0] s);
		pack_entry = {32'h0000_0000, t, s, 3'h0};
	endfunction

	wire [ENTRY_W-1:0] rd_entry = pack_entry(idle_time_before_transition_q[tbl_rd_idx],
		idle_target_power_state_q[tbl_rd_idx]);
	logic [ENTRY_W-1:0] tbl_rd_data_q;
	logic               tbl_rd_valid_q;

	always_ff @(posedge mclk) begin
		if (srst) begin
			tbl_rd_data_q  <= '0;
			tbl_rd_valid_q <= 1'b0;
		end else begin
			tbl_rd_valid_q <= tbl_rd;
			if (tbl_rd)
				tbl_rd_data_q <= rd_entry;
		end
	end
	assign tbl_rd_data  = tbl_rd_data_q;
	assign tbl_rd_valid = tbl_rd_valid_q;
	assign cfg_rd_data  = {31'h0000_0000, auto_power_transition_enable_q};

	// ========================================
	// millisecond tick and idle timer
	localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
	logic [TW-1:0]      tick_cnt_q;
	logic [IDLE_TIME_BEFORE_TRANSITION_W-1:0]  idle_ms_q;
	logic [IDLE_TARGET_POWER_STATE_W-1:0]  cur_ps_q;
	logic               auto_trans_q;

	wire [IDLE_TIME_BEFORE_TRANSITION_W-1:0] cur_idle_time_before_transition  = idle_time_before_transition_q[cur_ps_q];
	wire [IDLE_TARGET_POWER_STATE_W-1:0] cur_idle_target_power_state  = idle_target_power_state_q[cur_ps_q];
	wire              restart   = busy || ps_set || auto_trans_q;
	wire              tick      = (tick_cnt_q == TW'(TICK_CYCLES - 1));
	wire              idle_full = &idle_ms_q;
	wire              fire      = auto_power_transition_enable_q && !restart
		&& (cur_idle_time_before_transition != '0)
		&& (idle_ms_q > cur_idle_time_before_transition);

	always_ff @(posedge mclk) begin
		if (srst || restart || tick)
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + TW'(1);
	end

	always_ff @(posedge mclk) begin
		if (srst || restart)
			idle_ms_q <= '0;
		else if (tick && !idle_full)
			idle_ms_q <= idle_ms_q + IDLE_TIME_BEFORE_TRANSITION_W'(1);
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cur_ps_q     <= '0;
			auto_trans_q <= 1'b0;
		end else begin
			auto_trans_q <= fire;
			if (ps_set)
				cur_ps_q <= ps_set_value;
			else if (fire)
				cur_ps_q <= cur_idle_target_power_state;
		end
	end
	assign cur_ps     = cur_ps_q;
	assign auto_trans = auto_trans_q;
endmodule

// File: apst_pkg.sv
// package of constants for the autonomous power state transition block
// assumes a single 250 MHz controller clock
package apst_pkg;
	// ========================================
	// table geometry
	localparam int unsigned NUM_ENTRIES      = 32;
	localparam int unsigned ENTRY_W          = 64;
	localparam int unsigned IDX_W            = 5;
	// ========================================
	// entry field layout
	localparam int unsigned IDLE_TIME_BEFORE_TRANSITION_LSB         = 8;
	localparam int unsigned IDLE_TIME_BEFORE_TRANSITION_W           = 24;
	localparam int unsigned IDLE_TARGET_POWER_STATE_LSB         = 3;
	localparam int unsigned IDLE_TARGET_POWER_STATE_W           = 5;
	// ========================================
	// config dword field layout and reset
	localparam int unsigned CFG_EN_BIT       = 0;
	localparam logic        CFG_EN_RESET     = 1'b0;
	// ========================================
	// timing
	localparam int unsigned CLK_PERIOD_PS    = 4000;
	localparam int unsigned MS_TIME_PS       = 1000000000;
	localparam int unsigned MS_CYCLES        = MS_TIME_PS / CLK_PERIOD_PS;
endpackage

// File: apst_host.sv
// host model: loads one table image after go
// assumes go pulses once after reset
`timescale 1ns/1ps
module apst_host
	import apst_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               go,
	output logic                    tbl_wr,
	output logic [IDX_W-1:0]        tbl_wr_idx,
	output logic [ENTRY_W-1:0]      tbl_wr_data
);
	logic [5:0] n_q = 6'h20;
	always_ff @(posedge mclk) begin
		if (go) n_q <= 6'h0;
		else if (!n_q[5]) n_q <= n_q + 6'h1;
	end
	// whole image in one pass, targets non-operational, reserved bits set
	assign tbl_wr      = !n_q[5];
	assign tbl_wr_idx  = n_q[4:0];
	assign tbl_wr_data = {32'hffff_ffff, 23'h0, n_q == 6'h0, 5'h3, 3'h7};
endmodule

// File: apst_assertions.sv
// checker for the apst core ports
// assumes mclk rising edge and srst synchronous
`timescale 1ns/1ps
module apst_assertions
	import apst_pkg::*;
#(parameter int unsigned NUM_PS = 32) (
	input wire logic mclk, srst, tbl_rd, busy, ps_set, tbl_rd_valid, auto_trans,
	input wire logic [IDX_W-1:0] tbl_rd_idx,
	input wire logic [IDLE_TARGET_POWER_STATE_W-1:0] ps_set_value, cur_ps,
	input wire logic [ENTRY_W-1:0] tbl_rd_data,
	input wire logic [31:0] cfg_rd_data
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	property p_en; auto_trans |-> $past(cfg_rd_data[0]); endproperty
	a_en: assert property (p_en) else $error("move while disabled");
	property p_rst; $fell(srst) |-> cfg_rd_data == 32'h0; endproperty
	a_rst: assert property (p_rst) else $error("enable not clear");
	property p_rd; tbl_rd |=> tbl_rd_valid; endproperty
	a_rd: assert property (p_rd) else $error("no read answer");
	property p_rsv; cfg_rd_data[31:1] == 0 && (!tbl_rd_valid || tbl_rd_data[63:32] == 0 && tbl_rd_data[2:0] == 0); endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	property p_uns; tbl_rd && tbl_rd_idx >= NUM_PS |=> tbl_rd_data == 64'h0; endproperty
	a_uns: assert property (p_uns) else $error("unsupported entry nonzero");
	property p_one; auto_trans |=> !auto_trans; endproperty
	a_one: assert property (p_one) else $error("move pulse too long");
	property p_busy; busy |=> !auto_trans [*4]; endproperty
	a_busy: assert property (p_busy) else $error("move soon after activity");
	property p_ps; ps_set |=> cur_ps == $past(ps_set_value) ##0 !auto_trans [*4]; endproperty
	a_ps: assert property (p_ps) else $error("state set wrong");
endmodule
bind apst_core apst_assertions #(.NUM_PS(NUM_PS)) i_apst_assertions (.*);

// File: autonomous_power_state_transition_tb.sv
// testbench for apst core with host model
// assumes 4 cycle millisecond and 8 supported states
`timescale 1ns/1ps
module autonomous_power_state_transition_tb;
	import apst_pkg::*;
	logic mclk = 0, srst = 1, cfg_wr = 0, tbl_rd = 0, busy = 0, ps_set = 0, go = 0, tbl_wr, tbl_rd_valid, auto_trans;
	logic [31:0] cfg_wr_data = 0, cfg_rd_data;
	logic [4:0] tbl_wr_idx, tbl_rd_idx = 0, ps_set_value = 0, cur_ps;
	logic [63:0] tbl_wr_data, tbl_rd_data;
	logic [68:0] rows [3] = '{{5'd0, 64'h118}, {5'd1, 64'h18}, {5'd31, 64'h0}};
	int fail_count = 0, checked = 0;
	always #2 mclk = ~mclk;
	apst_core #(.NUM_PS(8), .TICK_CYCLES(4)) i_apst_core (
		.mclk         (mclk),
		.srst         (srst),
		.cfg_wr       (cfg_wr),
		.cfg_wr_data  (cfg_wr_data),
		.tbl_wr       (tbl_wr),
		.tbl_wr_idx   (tbl_wr_idx),
		.tbl_wr_data  (tbl_wr_data),
		.tbl_rd       (tbl_rd),
		.tbl_rd_idx   (tbl_rd_idx),
		.tbl_rd_data  (tbl_rd_data),
		.tbl_rd_valid (tbl_rd_valid),
		.cfg_rd_data  (cfg_rd_data),
		.busy         (busy),
		.ps_set       (ps_set),
		.ps_set_value (ps_set_value),
		.cur_ps       (cur_ps),
		.auto_trans   (auto_trans)
	);
	apst_host i_apst_host (
		.mclk         (mclk),
		.go           (go),
		.tbl_wr       (tbl_wr),
		.tbl_wr_idx   (tbl_wr_idx),
		.tbl_wr_data  (tbl_wr_data)
	);
	task chk(input logic [63:0] s, e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task conclude;
		if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	initial begin
		cyc(16);
		srst = 0;
		go = 1;
		cyc(1);
		chk(cfg_rd_data, 0);
		go = 0;
		cyc(34);
		foreach (rows[i]) begin
			tbl_rd_idx = rows[i][68:64];
			tbl_rd = 1;
			cyc(1);
			tbl_rd = 0;
			chk(tbl_rd_valid, 1);
			chk(tbl_rd_data, rows[i][63:0]);
		end
		cyc(40);
		chk(cur_ps, 0);
		cfg_wr_data = 32'hffff_ffff;
		cfg_wr = 1;
		cyc(1);
		cfg_wr = 0;
		chk(cfg_rd_data, 1);
		repeat (40) if (cur_ps !== 5'h3) cyc(1);
		chk(cur_ps, 3);
		chk(auto_trans, 1);
		cyc(1);
		chk(auto_trans, 0);
		cyc(40);
		chk(cur_ps, 3);
		{ps_set, busy} = 2'b11;
		cyc(1);
		ps_set = 0;
		cyc(20);
		chk(cur_ps, 0);
		busy = 0;
		cyc(6);
		chk(cur_ps, 0);
		cyc(10);
		chk(cur_ps, 3);
		srst = 1;
		cyc(1);
		srst = 0;
		cyc(2);
		chk(cfg_rd_data, 0);
		chk(cur_ps, 0);
		conclude();
	end
	initial begin
		#4000;
		fail_count++;
		conclude();
	end
endmodule
